// ### logic/ptp_timestamp_frame_engine.sv
// Per-port timestamp engine: header insertion and frame modification
//
// Function
// - Four engines, one per port instance
// - Local time and common logic elsewhere
// - Standalone or header mode, selected
// - Standalone: timestamp only unfragmented express frames
// - Receive: capture arrival stamp for time frames
// - Legacy receive: arrival subseconds into reserved
// - IPv4 UDP: bad checksum fails, clear
// - IPv6 UDP: zero check, bad fails
// - Regenerate FCS; bad input keeps FCS bad
// - Transmit: capture departure stamp, queue it
// - Legacy transmit: take arrival subseconds
// - Correction plus departure plus delay, minus arrival
// - Delay term covers stamp point to line
// - Transmit: update FCS, clear IPv4 checksum
// - Header mode: stamp all, replace preamble
// - Extension low word: two zeros, subseconds
// - Packet type field always 00
// - Subport index carries port number
// - Extension type 01 or 10, per port
// - Extension top byte carries preemption state
// - Last header byte is CRC-8
// - Stamps from shared seconds/nanoseconds counter
`timescale 1ns/1ns
`include "ptp_frame_map.svh"
module ptp_timestamp_frame_engine
   import ptp_frame_pkg::*;
#(
   parameter logic [3:0]  PORT_INDEX  = 4'h0,
   parameter logic [29:0] TX_DELAY_NS = 30'h0,
   parameter logic [7:0]  CRC8_POLY   = 8'h07
) (
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        header_mode_in,
   input  wire logic        tx_dir_in,
   input  wire logic        legacy_e2e_in,
   input  wire logic        preempt_en_in,
   input  wire logic [7:0]  preempt_state_in,
   input  wire logic        express_in,
   input  wire logic        v4_clear_en_in,
   input  wire logic        v6_zero_chk_en_in,
   input  wire logic        udp_fail_in,
   input  wire logic [29:0] local_time_ns_in,
   input  wire logic [29:0] arrival_ns_in,
   input  wire logic [7:0]  in_data_in,
   input  wire logic        in_valid_in,
   input  wire logic        in_last_in,
   input  wire logic        in_err_in,
   output logic             in_ready_out,
   output logic [7:0]       out_data_out,
   output logic             out_valid_out,
   output logic             out_last_out,
   input  wire logic        out_ready_in,
   output logic             ts_valid_out,
   output logic [59:0]      ts_value_out
);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] crc32_step(input logic [31:0] c,
                                             input logic [7:0]  b);
      logic [31:0] r;
      r = c ^ {24'h0, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `CRC32_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic [7:0] crc8_step(input logic [7:0] c,
                                           input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ CRC8_POLY) : (r << 1);
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   state_s      s_q;
   state_s      s_d;
   logic [7:0]  hb;
   logic [31:0] ts_word;
   logic        take;
   logic        pop;
   logic        push;
   obyte_s      pv;
   logic [7:0]  b;
   logic [63:0] cf;
   logic [29:0] delta;
   logic [31:0] ic;

   // Reserved-field subsecond format: two zero bits then 30 bits
   assign ts_word = {2'h0, s_q.ts};

   // Header or regenerated preamble byte for the current index
   always_comb begin
      hb = `PRE_BYTE;
      if (s_q.idx == 4'h0) begin
         hb = `START_BYTE;
      end else if (!header_mode_in) begin
         hb = (s_q.idx == `HDR_LAST_IDX) ? `SFD_BYTE : `PRE_BYTE;
      end else begin
         case (s_q.idx)
            4'h1: hb = {`PKT_TYPE_CODE, PORT_INDEX,
                        preempt_en_in ? `EXT_TYPE_PRE
                                      : `EXT_TYPE_NOPRE};
            4'h2: hb = preempt_state_in;
            4'h3: hb = ts_word[31:24];
            4'h4: hb = ts_word[23:16];
            4'h5: hb = ts_word[15:8];
            4'h6: hb = ts_word[7:0];
            default: hb = s_q.hcrc;
         endcase
      end
   end

   // Residence correction: departure minus arrival plus fixed delay
   always_comb begin
      if (s_q.ts >= arrival_ns_in) begin
         delta = s_q.ts - arrival_ns_in + TX_DELAY_NS;
      end else begin
         delta = s_q.ts + `NS_PER_SEC - arrival_ns_in + TX_DELAY_NS;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d   = s_q;
      pop   = out_ready_in && (s_q.bcnt != 2'h0);
      push  = 1'b0;
      pv    = '0;
      b     = in_data_in;
      cf    = '0;
      ic    = s_q.icrc;
      take  = in_valid_in && s_q.rdy;
      s_d.tsv = 1'b0;
      if (pop) begin
         s_d.buf_q[0] = s_q.buf_q[1];
         s_d.bcnt     = s_q.bcnt - 2'h1;
      end
      case (s_q.st)
         ST_IDLE: begin
            // Line preamble is dropped; a fresh one is built later
            if (take && in_data_in == `SFD_BYTE) begin
               s_d.ts   = local_time_ns_in;
               s_d.expr = express_in;
               s_d.st   = ST_HDR;
               s_d.idx  = 4'h0;
               s_d.hcrc = 8'h0;
            end
         end
         ST_HDR: begin
            if (s_q.bcnt != 2'h2) begin
               push    = 1'b1;
               pv.data = hb;
               if (s_q.idx != 4'h0) begin
                  s_d.hcrc = crc8_step(s_q.hcrc, hb);
               end
               s_d.idx = s_q.idx + 4'h1;
               if (s_q.idx == `HDR_LAST_IDX) begin
                  s_d.st   = ST_BODY;
                  s_d.pos  = 16'h0;
                  s_d.icrc = `CRC32_INIT;
                  s_d.ocrc = `CRC32_INIT;
                  s_d.dn   = 4'h0;
                  s_d.ptp  = 1'b0;
                  s_d.v4   = 1'b0;
                  s_d.v6   = 1'b0;
                  s_d.bad  = 1'b0;
               end
            end
         end
         ST_BODY: begin
            if (take) begin
               ic       = crc32_step(s_q.icrc, in_data_in);
               s_d.icrc = ic;
               if (s_q.pos == `POS_ETYPE_LO) begin
                  s_d.ptp = s_q.dly[7] == `ETH_PTP_HI
                            && in_data_in == `ETH_PTP_LO;
                  s_d.v4  = s_q.dly[7] == `ETH_V4_HI
                            && in_data_in == `ETH_V4_LO;
                  s_d.v6  = s_q.dly[7] == `ETH_V6_HI
                            && in_data_in == `ETH_V6_LO;
               end
               if (s_q.pos == `POS_V4_PROTO && s_q.v4) begin
                  s_d.v4 = in_data_in == `IP_PROTO_UDP;
               end
               if (s_q.pos == `POS_V6_NEXT && s_q.v6) begin
                  s_d.v6 = in_data_in == `IP_PROTO_UDP;
               end
               // Legacy receive writes arrival subseconds, MSB first
               if (!header_mode_in && !tx_dir_in && legacy_e2e_in
                   && s_q.ptp && s_q.expr && s_q.pos >= `POS_RSV_FIRST
                   && s_q.pos <= `POS_RSV_LAST) begin
                  case (s_q.pos[1:0])
                     2'h2: b = ts_word[31:24];
                     2'h3: b = ts_word[23:16];
                     2'h0: b = ts_word[15:8];
                     default: b = ts_word[7:0];
                  endcase
               end
               // IPv4 UDP checksum zeroed when clearing is enabled, in standalone mode only
               if (!header_mode_in && s_q.v4 && v4_clear_en_in
                   && (s_q.pos == `POS_V4_CSUM
                       || s_q.pos == `POS_V4_CSUM + 16'h1)) begin
                  b = 8'h0;
               end
               if (s_q.v6 && s_q.pos == `POS_V6_CSUM) begin
                  s_d.v6z = in_data_in == 8'h0;
               end
               if (s_q.v6 && v6_zero_chk_en_in && s_q.v6z
                   && s_q.pos == `POS_V6_CSUM + 16'h1
                   && in_data_in == 8'h0) begin
                  s_d.bad = 1'b1;
               end
               if (s_q.dn == `DLY_DEPTH) begin
                  push     = 1'b1;
                  pv.data  = s_q.dly[0];
                  s_d.ocrc = crc32_step(s_q.ocrc, s_q.dly[0]);
               end else begin
                  s_d.dn = s_q.dn + 4'h1;
               end
               s_d.dly = {b, s_q.dly[7:1]};
               // Whole correction field sits in the delay line here
               if (!header_mode_in && tx_dir_in && legacy_e2e_in
                   && s_q.ptp && s_q.expr
                   && s_q.pos == `POS_CF_LAST) begin
                  for (int i = 0; i < 8; i++) begin
                     cf[8*(7-i) +: 8] = s_d.dly[i];
                  end
                  cf = cf + {18'h0, delta, 16'h0};
                  for (int i = 0; i < 8; i++) begin
                     s_d.dly[i] = cf[8*(7-i) +: 8];
                  end
               end
               s_d.pos = s_q.pos + 16'h1;
               if (in_last_in) begin
                  s_d.st  = ST_FCS;
                  s_d.idx = 4'h0;
                  if (ic != `CRC32_RESIDUE || in_err_in || udp_fail_in) begin
                     s_d.bad = 1'b1;
                  end
                  if (s_q.ptp && s_q.expr && !header_mode_in) begin
                     s_d.tsv   = 1'b1;
                     s_d.tsval = {arrival_ns_in, s_q.ts};
                  end
               end
            end
         end
         default: begin
            if (s_q.bcnt != 2'h2) begin
               push = 1'b1;
               if (s_q.idx < 4'h4) begin
                  pv.data  = s_q.dly[s_q.idx[1:0]];
                  s_d.ocrc = crc32_step(s_q.ocrc, pv.data);
               end else begin
                  // Uninverted CRC guarantees a failing FCS downstream
                  pv.data = s_q.bad ? s_q.ocrc[8*s_q.idx[1:0] +: 8]
                                    : ~s_q.ocrc[8*s_q.idx[1:0] +: 8];
               end
               pv.last = s_q.idx == `HDR_LAST_IDX;
               s_d.idx = s_q.idx + 4'h1;
               if (s_q.idx == `HDR_LAST_IDX) begin
                  s_d.st = ST_IDLE;
               end
            end
         end
      endcase
      if (push) begin
         s_d.buf_q[s_d.bcnt[0]] = pv;
         s_d.bcnt               = s_d.bcnt + 2'h1;
      end
      s_d.vld = s_d.bcnt != 2'h0;
      // Ready looks at the next state and count, so a taken byte always fits
      s_d.rdy = (s_d.st == ST_IDLE || s_d.st == ST_BODY)
                && s_d.bcnt != 2'h2;
   end

   // One clock per instance; mode inputs must already be in this domain
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_q    <= '0;
         s_q.st <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign in_ready_out  = s_q.rdy;
   assign out_data_out  = s_q.buf_q[0].data;
   assign out_last_out  = s_q.buf_q[0].last;
   assign out_valid_out = s_q.vld;
   assign ts_valid_out  = s_q.tsv;
   assign ts_value_out  = s_q.tsval;

   ////////////////////////////////////////////////////////////////////////
   hdr_pkt_type_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (s_q.st == ST_HDR && s_q.idx == 4'h1 && header_mode_in)
      |-> hb[7:6] == 2'h0) else $error("packet type not zero");
   hdr_subport_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (s_q.st == ST_HDR && s_q.idx == 4'h1 && header_mode_in)
      |-> hb[5:2] == PORT_INDEX) else $error("wrong subport index");
   hdr_ext_type_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (s_q.st == ST_HDR && s_q.idx == 4'h1 && header_mode_in)
      |-> hb[1:0] == (preempt_en_in ? 2'h2 : 2'h1))
      else $error("wrong extension type");
   hdr_ext_state_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (s_q.st == ST_HDR && s_q.idx == 4'h2 && header_mode_in)
      |-> hb == preempt_state_in) else $error("preemption state lost");
   hdr_ts_top_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (s_q.st == ST_HDR && s_q.idx == 4'h3 && header_mode_in)
      |-> hb[7:6] == 2'h0 && hb[5:0] == s_q.ts[29:24])
      else $error("bad subsecond high byte");
   hdr_length_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (s_q.st == ST_HDR && s_q.idx == 4'h7 && s_q.bcnt != 2'h2)
      |=> s_q.st == ST_BODY ##1 s_q.st == ST_BODY || !take)
      else $error("header not eight bytes");
   ts_capture_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (s_q.st == ST_IDLE && take && in_data_in == `SFD_BYTE)
      |=> s_q.ts == $past(local_time_ns_in) && s_q.st == ST_HDR)
      else $error("arrival stamp not captured");
   bad_fcs_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (s_q.st == ST_FCS && s_q.idx == 4'h4 && s_q.bcnt != 2'h2 && s_q.bad)
      |=> s_q.buf_q[s_q.bcnt - 2'h1].data == $past(s_q.ocrc[7:0]))
      else $error("bad frame left with good FCS");
   ready_room_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      s_q.rdy |-> s_q.bcnt != 2'h2) else $error("ready with full buffer");
endmodule

// ### inc/ptp_frame_map.svh
// Constants for the timestamp and frame-modification engine
`ifndef PTP_FRAME_MAP_SVH
`define PTP_FRAME_MAP_SVH
`define SFD_BYTE        8'hd5
`define PRE_BYTE        8'h55
`define START_BYTE      8'hfb
`define PKT_TYPE_CODE   2'h0
`define EXT_TYPE_NOPRE  2'h1
`define EXT_TYPE_PRE    2'h2
`define ETH_PTP_HI      8'h88
`define ETH_PTP_LO      8'hf7
`define ETH_V4_HI       8'h08
`define ETH_V4_LO       8'h00
`define ETH_V6_HI       8'h86
`define ETH_V6_LO       8'hdd
`define IP_PROTO_UDP    8'h11
`define POS_ETYPE_HI    16'h000c
`define POS_ETYPE_LO    16'h000d
`define POS_V4_PROTO    16'h0017
`define POS_V6_NEXT     16'h0014
`define POS_V4_CSUM     16'h0028
`define POS_V6_CSUM     16'h003c
`define POS_CF_LAST     16'h001d
`define POS_RSV_FIRST   16'h001e
`define POS_RSV_LAST    16'h0021
`define HDR_LAST_IDX    4'h7
`define DLY_DEPTH       4'h8
`define CRC32_INIT      32'hffffffff
`define CRC32_POLY      32'hedb88320
`define CRC32_RESIDUE   32'hdebb20e3
`define NS_PER_SEC      30'h3b9aca00
`endif

// ### inc/ptp_frame_pkg.sv
// Types for the timestamp and frame-modification engine
package ptp_frame_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_HDR  = 4'h2,
      ST_BODY = 4'h4,
      ST_FCS  = 4'h8
   } fsm_e;
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } obyte_s;
   typedef struct packed {
      fsm_e            st;
      logic [3:0]      idx;
      logic [15:0]     pos;
      logic [29:0]     ts;
      logic [7:0]      hcrc;
      logic [31:0]     icrc;
      logic [31:0]     ocrc;
      logic [7:0][7:0] dly;
      logic [3:0]      dn;
      logic            ptp;
      logic            v4;
      logic            v6;
      logic            v6z;
      logic            bad;
      logic            expr;
      logic [1:0]      bcnt;
      obyte_s [1:0]    buf_q;
      logic            vld;
      logic            rdy;
      logic            tsv;
      logic [59:0]     tsval;
   } state_s;
endpackage

// ### verif/mac_sink_model.sv
// Receiving MAC model: collects output bytes, optionally stalls ready
`timescale 1ns/1ns
module mac_sink_model (
   input  wire logic       clk_in,
   input  wire logic       arst_n_in,
   input  wire logic [7:0] data_in,
   input  wire logic       valid_in,
   input  wire logic       last_in,
   input  wire logic       stall_in,
   output logic            ready_out
);
   logic [7:0] got[$];
   int         last_at = -1;
   logic       ph = 1'b0;
   initial ready_out = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // Ready moves only off the sampling edge; stalls drop it every other cycle
   always @(negedge clk_in) begin
      ph <= ~ph;
      ready_out <= stall_in ? ph : 1'b1;
   end
   always @(posedge clk_in) begin
      if (arst_n_in === 1'b1 && valid_in === 1'b1 && ready_out === 1'b1) begin
         got.push_back(data_in);
         if (last_in === 1'b1) begin
            last_at = got.size() - 1;
         end
      end
   end
endmodule

// ### verif/ptp_timestamp_frame_engine_tb.sv
// Self-checking bench for the timestamp and frame-modification engine
`timescale 1ns/1ns
`include "ptp_frame_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module ptp_timestamp_frame_engine_tb;
   localparam logic [3:0] PORT = 4'h2;
   logic        clk_in = 0, arst_n_in = 0, header_mode_in = 0, legacy_e2e_in = 0;
   logic        preempt_en_in = 0, express_in = 1, udp_fail_in = 0;
   logic        in_valid_in = 0, in_last_in = 0, in_err_in = 0, stall = 0;
   logic        tx_dir_in = 0, v4_clear_en_in = 0, v6_zero_chk_en_in = 0;
   logic [7:0]  preempt_state_in = 8'h00, in_data_in = 8'h00;
   logic [29:0] local_time_ns_in = 30'h0, arrival_ns_in = 30'h0;
   logic        in_ready_out, out_valid_out, out_last_out, out_ready_in;
   logic        ts_valid_out;
   logic [7:0]  out_data_out;
   logic [59:0] ts_value_out, ts_cap;
   logic [7:0]  fr[$], ex[$], h[8];
   int          miscompares = 0, checks_done = 0, ts_cnt = 0;
   always #5 clk_in = ~clk_in;
   ptp_timestamp_frame_engine #(.PORT_INDEX(PORT)) dut (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .header_mode_in(header_mode_in),
      .tx_dir_in(tx_dir_in), .legacy_e2e_in(legacy_e2e_in),
      .preempt_en_in(preempt_en_in), .preempt_state_in(preempt_state_in),
      .express_in(express_in), .v4_clear_en_in(v4_clear_en_in),
      .v6_zero_chk_en_in(v6_zero_chk_en_in), .udp_fail_in(udp_fail_in),
      .local_time_ns_in(local_time_ns_in), .arrival_ns_in(arrival_ns_in),
      .in_data_in(in_data_in), .in_valid_in(in_valid_in),
      .in_last_in(in_last_in), .in_err_in(in_err_in),
      .in_ready_out(in_ready_out), .out_data_out(out_data_out),
      .out_valid_out(out_valid_out), .out_last_out(out_last_out),
      .out_ready_in(out_ready_in), .ts_valid_out(ts_valid_out),
      .ts_value_out(ts_value_out));
   mac_sink_model sink (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .data_in(out_data_out),
      .valid_in(out_valid_out), .last_in(out_last_out), .stall_in(stall),
      .ready_out(out_ready_in));
   always @(posedge clk_in) begin
      if (ts_valid_out === 1'b1) begin
         ts_cnt++;
         ts_cap = ts_value_out;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Reference checksums, written independently of the design
   function automatic logic [31:0] crc32(input logic [7:0] q[$]);
      logic [31:0] c;
      c = `CRC32_INIT;
      foreach (q[i]) begin
         c = c ^ {24'h0, q[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ `CRC32_POLY : c >> 1;
      end
      return ~c;
   endfunction
   function automatic logic [7:0] crc8();
      logic [7:0] c;
      c = 8'h00;
      for (int i = 1; i < 7; i++) begin
         c = c ^ h[i];
         for (int b = 0; b < 8; b++) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
      end
      return c;
   endfunction
   task automatic add_fcs(ref logic [7:0] q[$]);
      logic [31:0] f;
      f = crc32(q);
      for (int i = 0; i < 4; i++) q.push_back(f[8*i +: 8]);
   endtask
   task automatic build(input int n, input bit ptp, input bit stamp);
      fr.delete();
      for (int i = 0; i < n - 4; i++) fr.push_back(8'(i * 5 + 1));
      if (ptp) begin
         fr[12] = 8'h88;
         fr[13] = 8'hf7;
      end
      ex = fr;
      // Arrival subseconds, two zero bits on top, most significant first
      if (stamp) {ex[30], ex[31], ex[32], ex[33]} = {2'b00, local_time_ns_in};
      add_fcs(fr);
      add_fcs(ex);
   endtask
   task automatic put(input logic [7:0] b, input logic l);
      int k;
      k = 0;
      @(negedge clk_in);
      in_data_in = b;
      in_valid_in = 1'b1;
      in_last_in = l;
      while (in_ready_out !== 1'b1 && k < 100) begin
         @(negedge clk_in);
         k++;
      end
      if (k == 100) `CHK(1'b0, 1'b1)
   endtask
   task automatic send(input bit bad);
      sink.got.delete();
      sink.last_at = -1;
      put(`PRE_BYTE, 1'b0);
      put(`PRE_BYTE, 1'b0);
      put(`SFD_BYTE, 1'b0);
      foreach (fr[i]) begin
         in_err_in = bad && (i == fr.size() - 1);
         put(fr[i], i == fr.size() - 1);
      end
      @(negedge clk_in);
      in_valid_in = 1'b0;
      in_last_in = 1'b0;
      in_err_in = 1'b0;
   endtask
   task automatic expect_frame(input bit bad, input int ts_exp);
      int k;
      k = 0;
      while (sink.last_at < 0 && k < 400) begin
         @(negedge clk_in);
         k++;
      end
      h = '{8'hfb, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hd5};
      if (header_mode_in) begin
         h[1] = {2'b00, PORT, preempt_en_in ? 2'b10 : 2'b01};
         h[2] = preempt_state_in;
         {h[3], h[4], h[5], h[6]} = {2'b00, local_time_ns_in};
         h[7] = crc8();
      end
      `CHK(sink.last_at, 8 + ex.size() - 1)
      for (int i = 0; i < 8; i++) `CHK(sink.got[i], h[i])
      for (int i = 0; i < ex.size() - (bad ? 4 : 0); i++) `CHK(sink.got[8 + i], ex[i])
      if (bad) `CHK({sink.got[$-3], sink.got[$-2], sink.got[$-1], sink.got[$]} ==
                    {ex[$-3], ex[$-2], ex[$-1], ex[$]}, 1'b0)
      `CHK(ts_cnt, ts_exp)
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_header();
      header_mode_in = 1'b1;
      local_time_ns_in = 30'h2a5f_1c3b;
      for (int p = 0; p < 2; p++) begin
         preempt_en_in = p[0];
         preempt_state_in = 8'h3c ^ 8'(p);
         build(40, 1'b1, 1'b0);
         send(1'b0);
         expect_frame(1'b0, ts_cnt);
      end
      $display("Test header done");
   endtask
   task automatic t_plain();
      header_mode_in = 1'b0;
      build(8, 1'b0, 1'b0);
      send(1'b0);
      expect_frame(1'b0, ts_cnt);
      $display("Test plain done");
   endtask
   task automatic t_ptp();
      int n;
      legacy_e2e_in = 1'b1;
      local_time_ns_in = 30'h1234_5678;
      arrival_ns_in = 30'h0abc_def1;
      n = ts_cnt;
      build(64, 1'b1, 1'b1);
      send(1'b0);
      expect_frame(1'b0, n + 1);
      `CHK(ts_cap, {arrival_ns_in, local_time_ns_in})
      express_in = 1'b0;
      build(64, 1'b1, 1'b0);
      send(1'b0);
      expect_frame(1'b0, n + 1);
      express_in = 1'b1;
      $display("Test ptp done");
   endtask
   task automatic t_bad();
      build(48, 1'b0, 1'b0);
      send(1'b1);
      expect_frame(1'b1, ts_cnt);
      udp_fail_in = 1'b1;
      send(1'b0);
      expect_frame(1'b1, ts_cnt);
      udp_fail_in = 1'b0;
      $display("Test bad done");
   endtask
   task automatic t_stall();
      header_mode_in = 1'b1;
      stall = 1'b1;
      build(30, 1'b0, 1'b0);
      for (int r = 0; r < 2; r++) begin
         send(1'b0);
         expect_frame(1'b0, ts_cnt);
      end
      stall = 1'b0;
      $display("Test stall done");
   endtask
   task automatic t_tx();
      logic [63:0] c;
      int n;
      header_mode_in = 1'b0;
      tx_dir_in = 1'b1;
      legacy_e2e_in = 1'b1;
      local_time_ns_in = 30'h0000_0100;
      arrival_ns_in = 30'h0000_0040;
      n = ts_cnt;
      build(64, 1'b1, 1'b0);
      ex = fr[0:$-4];
      c = '0;
      for (int i = 22; i < 30; i++) c = {c[55:0], ex[i]};
      // Departure 0x100 minus arrival 0x40, in 2^-16 ns units
      c = c + 64'h0000_0000_00c0_0000;
      for (int i = 0; i < 8; i++) ex[22 + i] = c[8*(7-i) +: 8];
      add_fcs(ex);
      send(1'b0);
      expect_frame(1'b0, n + 1);
      `CHK(ts_cap, {arrival_ns_in, local_time_ns_in})
      tx_dir_in = 1'b0;
      legacy_e2e_in = 1'b0;
      v4_clear_en_in = 1'b1;
      build(64, 1'b0, 1'b0);
      fr = fr[0:$-4];
      {fr[12], fr[13], fr[23]} = {8'h08, 8'h00, 8'h11};
      ex = fr;
      {ex[40], ex[41]} = 16'h0;
      add_fcs(fr);
      add_fcs(ex);
      send(1'b0);
      expect_frame(1'b0, ts_cnt);
      v4_clear_en_in = 1'b0;
      v6_zero_chk_en_in = 1'b1;
      build(70, 1'b0, 1'b0);
      fr = fr[0:$-4];
      {fr[12], fr[13], fr[20], fr[60], fr[61]} = {16'h86dd, 8'h11, 16'h0};
      ex = fr;
      add_fcs(fr);
      add_fcs(ex);
      send(1'b0);
      expect_frame(1'b1, ts_cnt);
      v6_zero_chk_en_in = 1'b0;
      $display("Test tx done");
   endtask
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (5) @(negedge clk_in);
      arst_n_in = 1'b1;
      repeat (2) @(negedge clk_in);
      t_header();
      t_plain();
      t_ptp();
      t_bad();
      t_stall();
      t_tx();
      report_and_stop();
   end
endmodule
